// ---- rtl/ate_timer_regs.v ----
`include "ate_timer_map.vh"
`timescale 1ns/1ps
`default_nettype none
module ate_timer_regs #(
  parameter CNT_W = 32,
  parameter PRESC_W = 32,
  parameter SYNC_CYCLES = `ATE_SYNC_CYCLES
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output wire pslverr_o,
  output reg [31:0] prdata_o,
  // Asynchronous timer core
  input wire [CNT_W-1:0] counter_i,
  input wire [PRESC_W-1:0] prescaler_i,
  input wire overflow_i,
  input wire clock_busy_i,
  // Events
  output reg irq_o,
  output reg wake_o
);
  reg [31:0] status_flags_q;
  reg [31:0] irq_mask_q;
  reg [31:0] wake_enable_q;
  reg [31:0] alarm0_q;
  reg [31:0] alarm1_q;
  reg [`ATE_SEL_W-1:0] tap_sel_q;
  reg tap_q;
  reg wrap_q;
  reg match0_q;
  reg match1_q;
  reg clkbusy_q;
  reg [31:0] rd_d;
  reg [31:0] events_d;
  wire [PRESC_W-1:0] presc_s;
  wire [CNT_W-1:0] cnt_s;
  wire [1:0] misc_s;
  wire busy;
  wire ready_pulse;
  wire wr_en;
  wire rd_en;
  wire guarded_wr;
  wire tap_now;
  wire match0_now;
  wire match1_now;

  function is_guarded;
    input [7:0] a;
    begin
      is_guarded = (a == `ATE_OFF_FLAG_CLEAR) || (a == `ATE_OFF_WAKE_EN) || (a == `ATE_OFF_ALARM0) ||
        (a == `ATE_OFF_ALARM1) || (a == `ATE_OFF_INTERVAL0);
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = is_guarded(a) || (a == `ATE_OFF_STATUS) || (a == `ATE_OFF_IRQ_EN) ||
        (a == `ATE_OFF_IRQ_DIS) || (a == `ATE_OFF_IRQ_MASK);
    end
  endfunction

  function rise;
    input now;
    input last;
    begin
      rise = now && !last;
    end
  endfunction

  // Input synchronisers
  ate_sync2 #(.W(PRESC_W)) u_sync_presc (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .d_i(prescaler_i),
    .q_o(presc_s)
  );
  ate_sync2 #(.W(CNT_W)) u_sync_cnt (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .d_i(counter_i),
    .q_o(cnt_s)
  );
  ate_sync2 #(.W(2)) u_sync_misc (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .d_i({clock_busy_i, overflow_i}),
    .q_o(misc_s)
  );

  // Bus decode
  assign pready_o = 1'b1;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  assign pslverr_o = psel_i && penable_i && !is_mapped(paddr_i);
  assign guarded_wr = wr_en && is_guarded(paddr_i) && !busy;

  // Busy after guarded write
  ate_busy_timer #(.CYCLES(SYNC_CYCLES)) u_busy (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .start_i(guarded_wr),
    .busy_o(busy),
    .done_o(ready_pulse)
  );

  // Event detection
  assign tap_now = presc_s[tap_sel_q];
  assign match0_now = (cnt_s == alarm0_q[CNT_W-1:0]);
  assign match1_now = (cnt_s == alarm1_q[CNT_W-1:0]);

  always @*
  begin
    events_d = 32'h00000000;
    events_d[`ATE_BIT_WRAP] = rise(misc_s[0], wrap_q);
    events_d[`ATE_BIT_MATCH0] = rise(match0_now, match0_q);
    events_d[`ATE_BIT_MATCH1] = rise(match1_now, match1_q);
    events_d[`ATE_BIT_INTERVAL0] = rise(tap_now, tap_q);
    events_d[`ATE_BIT_READY] = ready_pulse;
    events_d[`ATE_BIT_SOURCE_CLOCK_READY_FLAG] = rise(clkbusy_q, misc_s[1]);
  end

  always @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      tap_q <= 1'b0;
      wrap_q <= 1'b0;
      match0_q <= 1'b0;
      match1_q <= 1'b0;
      clkbusy_q <= 1'b0;
    end
    else
    begin
      tap_q <= tap_now;
      wrap_q <= misc_s[0];
      match0_q <= match0_now;
      match1_q <= match1_now;
      clkbusy_q <= misc_s[1];
    end
  end

  // Status flags, set wins over clear
  localparam [31:0] FLAG_BITS = `ATE_IRQ_MASK;
  wire [31:0] flags_next;
  wire clear_hit;
  assign clear_hit = guarded_wr && (paddr_i == `ATE_OFF_FLAG_CLEAR);
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1)
    begin : g_flag
      wire clr_bit;
      wire set_bit;
      assign clr_bit = clear_hit && pwdata_i[gi];
      assign set_bit = events_d[gi];
      assign flags_next[gi] = FLAG_BITS[gi] && (set_bit || (status_flags_q[gi] && !clr_bit));
    end
  endgenerate

  always @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      status_flags_q <= `ATE_RESET_WORD;
    else
      status_flags_q <= flags_next;
  end

  // Interrupt mask
  wire [31:0] mask_set;
  wire [31:0] mask_clr;
  assign mask_set = (wr_en && paddr_i == `ATE_OFF_IRQ_EN) ? (pwdata_i & `ATE_IRQ_MASK) : 32'h00000000;
  assign mask_clr = (wr_en && paddr_i == `ATE_OFF_IRQ_DIS) ? pwdata_i : 32'h00000000;
  always @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      irq_mask_q <= `ATE_RESET_WORD;
    else
      irq_mask_q <= (irq_mask_q | mask_set) & ~mask_clr;
  end

  // Guarded configuration registers
  always @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      wake_enable_q <= `ATE_RESET_WORD;
      alarm0_q <= `ATE_RESET_WORD;
      alarm1_q <= `ATE_RESET_WORD;
      tap_sel_q <= 5'h00;
    end
    else if (guarded_wr)
    begin
      case (paddr_i)
        `ATE_OFF_WAKE_EN:
        begin
          wake_enable_q <= pwdata_i & `ATE_EVENT_MASK;
        end
        `ATE_OFF_ALARM0:
        begin
          alarm0_q <= pwdata_i;
        end
        `ATE_OFF_ALARM1:
        begin
          alarm1_q <= pwdata_i;
        end
        `ATE_OFF_INTERVAL0:
        begin
          tap_sel_q <= pwdata_i[`ATE_SEL_W-1:0];
        end
        default:
        begin
          tap_sel_q <= tap_sel_q;
        end
      endcase
    end
  end

  // Interrupt output
  always @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(status_flags_q & irq_mask_q);
  end

  // Wake output
  always @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      wake_o <= 1'b0;
    else
      wake_o <= |(events_d & wake_enable_q);
  end

  // Read data
  always @*
  begin
    rd_d = 32'h00000000;
    case (paddr_i)
      `ATE_OFF_STATUS:
      begin
        rd_d = status_flags_q | ({31'h00000000, busy} << `ATE_BIT_BUSY) |
          ({31'h00000000, clkbusy_q} << 28);
      end
      `ATE_OFF_IRQ_MASK:
      begin
        rd_d = irq_mask_q;
      end
      `ATE_OFF_WAKE_EN:
      begin
        rd_d = busy ? 32'h00000000 : wake_enable_q;
      end
      `ATE_OFF_ALARM0:
      begin
        rd_d = busy ? 32'h00000000 : alarm0_q;
      end
      `ATE_OFF_ALARM1:
      begin
        rd_d = busy ? 32'h00000000 : alarm1_q;
      end
      `ATE_OFF_INTERVAL0:
      begin
        rd_d = busy ? 32'h00000000 : {27'h0000000, tap_sel_q};
      end
      default:
      begin
        rd_d = 32'h00000000;
      end
    endcase
  end

  // Read data register
  always @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      prdata_o <= 32'h00000000;
    else if (rd_en)
      prdata_o <= rd_d;
  end
endmodule // ate_timer_regs
`default_nettype wire

// ---- common/ate_timer_map.vh ----
`ifndef ATE_TIMER_MAP_VH
`define ATE_TIMER_MAP_VH
`define ATE_OFF_STATUS 8'h08
`define ATE_OFF_FLAG_CLEAR 8'h0C
`define ATE_OFF_IRQ_EN 8'h10
`define ATE_OFF_IRQ_DIS 8'h14
`define ATE_OFF_IRQ_MASK 8'h18
`define ATE_OFF_WAKE_EN 8'h1C
`define ATE_OFF_ALARM0 8'h20
`define ATE_OFF_ALARM1 8'h24
`define ATE_OFF_INTERVAL0 8'h30
`define ATE_BIT_WRAP 0
`define ATE_BIT_MATCH0 8
`define ATE_BIT_MATCH1 9
`define ATE_BIT_INTERVAL0 16
`define ATE_BIT_BUSY 24
`define ATE_BIT_READY 25
`define ATE_BIT_SOURCE_CLOCK_READY_FLAG 29
`define ATE_EVENT_MASK 32'h00010301
`define ATE_IRQ_MASK 32'h22010301
`define ATE_RESET_WORD 32'h00000000
`define ATE_SEL_W 5
`define ATE_SYNC_CYCLES 4
`endif

// ---- rtl/ate_sync2.v ----
`timescale 1ns/1ps
`default_nettype none
module ate_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // Data
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  always @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end
    else
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule // ate_sync2
`default_nettype wire

// ---- rtl/ate_busy_timer.v ----
`timescale 1ns/1ps
`default_nettype none
module ate_busy_timer #(
  parameter CYCLES = 4
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // Control
  input wire start_i,
  output wire busy_o,
  output wire done_o
);
  reg [7:0] cnt_q;
  always @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      cnt_q <= 8'h00;
    else if (start_i)
      cnt_q <= CYCLES[7:0];
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  assign busy_o = (cnt_q != 8'h00);
  assign done_o = (cnt_q == 8'h01);
endmodule // ate_busy_timer
`default_nettype wire

// ---- tb/ate_timer_regs_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module ate_chk (
  // Bus
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [31:0] prdata_o,
  // Events
  input wire logic irq_o,
  input wire logic wake_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire acc = psel_i && penable_i;
  wire wr = acc && pwrite_i;
  ready_now_a: assert property (acc |-> pready_o) else $error("no ready");
  unmapped_err_a: assert property (acc && paddr_i == 8'h40 |-> pslverr_o) else $error("no error");
  mask_ok_a: assert property (acc && paddr_i == 8'h18 |-> !pslverr_o) else $error("bad error");
  wake_pulse_a: assert property (wake_o |=> !wake_o) else $error("long wake");
  reset_quiet_a: assert property (disable iff (1'b0) !rstn_i |=> !irq_o && !wake_o) else $error("reset");
  mask_off_a: assert property (wr && paddr_i == 8'h14 && pwdata_i == 32'hFFFFFFFF |-> ##2 !irq_o)
    else $error("irq on");
  busy_zero_a: assert property (wr && paddr_i == 8'h1C ##2 psel_i && !penable_i && !pwrite_i
    && paddr_i == 8'h1C |=> prdata_o == 32'h00000000) else $error("busy read");
  read_hold_a: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o)) else $error("moved");
  cover property (wake_o);
  cover property ($rose(irq_o));
  cover property (acc && pslverr_o);
endmodule // ate_chk
bind ate_timer_regs ate_chk ate_chk_i (.ref_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pready_o, .pslverr_o, .prdata_o, .irq_o, .wake_o);
`default_nettype wire

// ---- tb/ate_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ate_core_model #(
  parameter logic [31:0] LOAD = 32'hFFFFFFF0
) (
  // Control
  input wire logic ref_clk_i,
  input wire logic run_i,
  input wire logic load_i,
  input wire logic busy_i,
  // Core side
  output logic [31:0] cnt_o,
  output logic ovf_o,
  output logic busy_o
);
  initial cnt_o = 32'h00000000;
  always @(posedge ref_clk_i)
  begin
    if (load_i)
      cnt_o <= LOAD;
    else if (run_i)
      cnt_o <= cnt_o + 32'h00000001;
    busy_o <= busy_i;
  end
  assign ovf_o = &cnt_o[31:3];
endmodule // ate_core_model
`default_nettype wire

// ---- tb/test_timer_event_irq_wake_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_timer_event_irq_wake_regs;
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic run_i = 1'b0, load_i = 1'b0, busy_i = 1'b0, e;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h00000000, r;
  logic [7:0] offs [5] = '{8'h18, 8'h1C, 8'h20, 8'h24, 8'h30};
  wire logic pready_o, pslverr_o, irq_o, wake_o, ovf_o, busy_o;
  wire logic [31:0] prdata_o, cnt_o;
  int mismatches = 0;
  int total_checks = 0;
  int wakes = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (wake_o === 1'b1) wakes++;
  ate_core_model ate_core_model_i (.ref_clk_i, .run_i, .load_i, .busy_i, .cnt_o, .ovf_o, .busy_o);
  ate_timer_regs ate_timer_regs_i (.ref_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pready_o, .pslverr_o, .prdata_o, .counter_i(cnt_o), .prescaler_i(cnt_o),
    .overflow_i(ovf_o), .clock_busy_i(busy_o), .irq_o, .wake_o);
  task automatic report_and_stop;
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h00000000);
    chk(r, x);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  initial
  begin
    #20us;
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    idle(3);
    rstn_i <= 1'b1;
    idle(1);
    foreach (offs[i]) rd(offs[i], 32'h00000000);
    rd(8'h40, 32'h00000000);
    chk({31'h0, e}, 32'h00000001);
    bus(1'b1, 8'h10, 32'h22010301);
    rd(8'h18, 32'h22010301);
    bus(1'b1, 8'h14, 32'h00000001);
    rd(8'h18, 32'h22010300);
    bus(1'b1, 8'h10, 32'h00000001);
    bus(1'b1, 8'h1C, 32'h00000001);
    rd(8'h1C, 32'h00000000);
    idle(6);
    rd(8'h1C, 32'h00000001);
    bus(1'b1, 8'h20, 32'hFFFFFFF4);
    bus(1'b1, 8'h24, 32'h00000007);
    idle(6);
    rd(8'h20, 32'hFFFFFFF4);
    rd(8'h24, 32'h00000000);
    bus(1'b1, 8'h24, 32'h00000010);
    idle(6);
    rd(8'h24, 32'h00000010);
    bus(1'b1, 8'h30, 32'h000000E3);
    idle(6);
    rd(8'h30, 32'h00000003);
    load_i <= 1'b1;
    idle(1);
    load_i <= 1'b0;
    run_i <= 1'b1;
    busy_i <= 1'b1;
    idle(60);
    run_i <= 1'b0;
    busy_i <= 1'b0;
    idle(8);
    rd(8'h08, 32'h22010301);
    chk({31'h0, irq_o}, 32'h00000001);
    chk(wakes, 32'h00000001);
    bus(1'b1, 8'h1C, 32'h00000001);
    bus(1'b1, 8'h0C, 32'hFFFFFFFF);
    idle(6);
    rd(8'h08, 32'h22010301);
    bus(1'b1, 8'h0C, 32'h22010301);
    idle(6);
    rd(8'h08, 32'h02000000);
    bus(1'b1, 8'h14, 32'hFFFFFFFF);
    idle(1);
    chk({31'h0, irq_o}, 32'h00000000);
    bus(1'b1, 8'h1C, 32'h00010100);
    idle(6);
    wakes = 0;
    load_i <= 1'b1;
    idle(1);
    load_i <= 1'b0;
    run_i <= 1'b1;
    idle(60);
    run_i <= 1'b0;
    idle(8);
    chk(wakes, 32'h00000005);
    report_and_stop();
  end
endmodule // test_timer_event_irq_wake_regs
`default_nettype wire
